// file: hdl/rotdp_params.svh
`ifndef ROTDP_PARAMS_SVH
`define ROTDP_PARAMS_SVH
// Opcode fields, bits 15:10 of the instruction word
`define ROTDP_OPC_RLC      6'h0D
`define ROTDP_OPC_RLN      6'h11
`define ROTDP_OPC_RRC      6'h0C
`define ROTDP_OPC_MSB      15
`define ROTDP_OPC_LSB      10
`define ROTDP_DEST_BIT     9
`define ROTDP_ACC_BIT      8
`define ROTDP_ILO_MAX      8'h5F
`define ROTDP_ACC_SPLIT    8'h60
`define ROTDP_ACC_HI_BANK  4'hF
`define ROTDP_W_RESET      8'h00
`define ROTDP_C_RESET      1'b0
`endif

// file: hdl/rotdp_pkg.sv
`default_nettype none
package rotdp_pkg;
  typedef enum logic [3:0] {
    ROTDP_Q1 = 4'h1,
    ROTDP_Q2 = 4'h2,
    ROTDP_Q3 = 4'h4,
    ROTDP_Q4 = 4'h8
  } rotdp_q_e;
  typedef enum logic [1:0] {
    ROTDP_OP_NONE = 2'h0,
    ROTDP_OP_RLC  = 2'h1,
    ROTDP_OP_RLN  = 2'h2,
    ROTDP_OP_RRC  = 2'h3
  } rotdp_op_e;
endpackage
`default_nettype wire

// file: hdl/rotdp_shifter.sv
`include "rotdp_params.svh"
`default_nettype none
module rotdp_shifter
  import rotdp_pkg::*;
(
  input  wire rotdp_op_e  op,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  always_comb begin
    result    = operand;
    carry_out = carry_in;
    unique case (op)
      ROTDP_OP_RLC: begin
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      ROTDP_OP_RLN: begin
        result    = {operand[6:0], operand[7]};
      end
      ROTDP_OP_RRC: begin
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      ROTDP_OP_NONE: begin
        result    = operand;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: hdl/rotdp_core.sv
// Function
// - Decode in Q1, read file in Q2, rotate in Q3, write working register in Q4, file register one cycle later.
// - Rotate left no carry: bit n to n+1, bit 7 to bit 0, carry kept.
// - Destination bit 1 writes file register back; 0 writes working register.
// - Access bit 0 uses access bank; 1 uses bank select register bank.
// - Extended set, access bit 0, address at most 95: indexed literal offset.
// - Rotate right through carry: bit n to n-1, bit 0 into carry.
// - Rotate left through carry: bit 7 to carry, old carry to bit 0.
// - Rotate right through carry: old carry into result bit 7.
`include "rotdp_params.svh"
`default_nettype none
module rotdp_core
  import rotdp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [7:0]  fsr2_base,
  input  wire logic [7:0]  file_rdata,
  output logic      [11:0] file_addr,
  output logic             file_rd,
  output logic             file_wr,
  output logic      [7:0]  file_wdata,
  output logic      [7:0]  w_reg,
  output logic             carry_flag,
  output logic             neg_flag,
  output logic             zero_flag,
  output logic      [3:0]  q_phase,
  output logic             instr_done,
  output logic             instr_hit
);
  rotdp_q_e   q;
  rotdp_op_e  op;
  logic       dest_f;
  logic [7:0] operand;
  logic [7:0] result;
  logic       next_carry;
  rotdp_op_e  dec_op;
  logic [5:0] opc;
  logic [7:0] faddr;
  logic       acc;
  logic [11:0] next_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-cycle sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= ROTDP_Q1;
    end else if (clk_en) begin
      unique case (q)
        ROTDP_Q1: q <= ROTDP_Q2;
        ROTDP_Q2: q <= ROTDP_Q3;
        ROTDP_Q3: q <= ROTDP_Q4;
        ROTDP_Q4: q <= ROTDP_Q1;
        // A corrupted phase code falls back to Q1 rather than stalling the core
        default:  q <= ROTDP_Q1;
      endcase
    end
  end
  assign q_phase = q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign opc   = instr_word[`ROTDP_OPC_MSB:`ROTDP_OPC_LSB];
  assign faddr = instr_word[7:0];
  assign acc   = instr_word[`ROTDP_ACC_BIT];

  always_comb begin
    if (!instr_valid) begin
      dec_op = ROTDP_OP_NONE;
    end else if (opc == `ROTDP_OPC_RLC) begin
      dec_op = ROTDP_OP_RLC;
    end else if (opc == `ROTDP_OPC_RLN) begin
      dec_op = ROTDP_OP_RLN;
    end else if (opc == `ROTDP_OPC_RRC) begin
      dec_op = ROTDP_OP_RRC;
    end else begin
      dec_op = ROTDP_OP_NONE;
    end
  end

  // Operand address: indexed offset beats access bank in the low window
  always_comb begin
    if (!acc && ext_set_en && faddr <= `ROTDP_ILO_MAX) begin
      next_addr = {4'h0, 8'(fsr2_base + faddr)};
    end else if (!acc) begin
      next_addr = (faddr < `ROTDP_ACC_SPLIT) ? {4'h0, faddr}
                                             : {`ROTDP_ACC_HI_BANK, faddr};
    end else begin
      next_addr = {bank_select_reg, faddr};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op <= ROTDP_OP_NONE;
    end else if (clk_en && q == ROTDP_Q1) begin
      op <= dec_op;
    end
  end

  // Destination held for the whole cycle; the word may change after Q1
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dest_f <= 1'b0;
    end else if (clk_en && q == ROTDP_Q1) begin
      dest_f <= instr_word[`ROTDP_DEST_BIT];
    end
  end

  // Registered so the file sees a steady address through Q2 and the write-back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      file_addr <= 12'h000;
    end else if (clk_en && q == ROTDP_Q1) begin
      file_addr <= next_addr;
    end
  end
  assign instr_hit = (op != ROTDP_OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Read in Q2, rotate in Q3
  // Strobe is combinational so the file answers inside Q2, not a cycle late
  assign file_rd = (q == ROTDP_Q2) && (op != ROTDP_OP_NONE);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      operand <= 8'h00;
    end else if (clk_en && file_rd) begin
      operand <= file_rdata;
    end
  end

  logic [7:0] rot_res;
  logic       rot_c;
  rotdp_shifter u_shift (
    .op        (op),
    .operand   (operand),
    .carry_in  (carry_flag),
    .result    (rot_res),
    .carry_out (rot_c)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result <= 8'h00;
    end else if (clk_en && q == ROTDP_Q3) begin
      result <= rot_res;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      next_carry <= `ROTDP_C_RESET;
    end else if (clk_en && q == ROTDP_Q3) begin
      next_carry <= rot_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write working register and flags in Q4; file write strobe follows one cycle later
  logic wr_q4;
  assign wr_q4 = (q == ROTDP_Q4) && (op != ROTDP_OP_NONE);

  // Strobe lags Q4 by one cycle so the data register is settled when it rises
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      file_wr <= 1'b0;
    end else if (clk_en) begin
      file_wr <= wr_q4 && dest_f;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      file_wdata <= 8'h00;
    end else if (clk_en) begin
      file_wdata <= result;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_reg <= `ROTDP_W_RESET;
    end else if (clk_en && wr_q4 && !dest_f) begin
      w_reg <= result;
    end
  end

  // Written on every rotate; the no-carry rotate passes its own carry through
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      carry_flag <= `ROTDP_C_RESET;
    end else if (clk_en && wr_q4) begin
      carry_flag <= next_carry;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      neg_flag  <= 1'b0;
      zero_flag <= 1'b0;
    end else if (clk_en && wr_q4) begin
      neg_flag  <= result[7];
      zero_flag <= (result == 8'h00);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      instr_done <= 1'b0;
    end else if (clk_en) begin
      instr_done <= wr_q4;
    end
  end
endmodule
`default_nettype wire

// file: verification/rotdp_checker.sv
`include "rotdp_params.svh"
`default_nettype none
module rotdp_checker (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        file_rd,
  input wire logic        file_wr,
  input wire logic [7:0]  w_reg,
  input wire logic        carry_flag,
  input wire logic [3:0]  q_phase,
  input wire logic        instr_done,
  input wire logic        instr_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_phase_wrap: assert property (clk_en && q_phase == 4'h8 |=> q_phase == 4'h1)
    else $error("phase did not wrap");
  a_read_in_q2: assert property (file_rd |-> q_phase == 4'h2 && instr_hit)
    else $error("read outside Q2");
  a_rotate_reads: assert property (clk_en && q_phase == 4'h1 && instr_valid
    && instr_word[15:10] == `ROTDP_OPC_RRC |=> file_rd) else $error("no operand read");
  a_done_after_q4: assert property (clk_en && q_phase == 4'h8 && instr_hit |=> instr_done)
    else $error("done missing");
  a_write_with_done: assert property (file_wr |-> instr_done)
    else $error("write without done");
  a_w_kept: assert property (file_wr |-> $stable(w_reg))
    else $error("working reg changed on file write");
  a_state_quiet: assert property (!(clk_en && q_phase == 4'h8)
    |=> $stable(carry_flag) && $stable(w_reg)) else $error("update outside Q4");
  // Carry must survive the whole rotate without carry
  a_noc_keeps_c: assert property (clk_en && q_phase == 4'h1 && instr_valid
    && instr_word[15:10] == `ROTDP_OPC_RLN ##1 clk_en [*3] |=> $stable(carry_flag))
    else $error("carry changed");
  a_freeze_holds: assert property (!clk_en |=> $stable(q_phase) && $stable(w_reg)
    && $stable(carry_flag)) else $error("state moved while disabled");
endmodule
`default_nettype wire

// file: verification/rotdp_tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        instr_valid = 1'b0;
  logic        ext_set_en = 1'b0;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [7:0]  fsr2_base = 8'h00;
  logic [7:0]  file_rdata = 8'h00;
  logic [15:0] instr_word = 16'h0000;
  logic [11:0] file_addr;
  logic        file_rd, file_wr, neg_flag, zero_flag, carry_flag, instr_done, instr_hit;
  logic [7:0]  file_wdata, w_reg;
  logic [3:0]  q_phase;
  logic [7:0]  mw = 8'h00;
  logic        mc = 1'b0;
  logic [1:0]  mnz = 2'b00;
  logic        clk_en = 1'b1;
  logic [5:0]  ops [4] = '{6'h0D, 6'h11, 6'h0C, 6'h12};
  integer      seed = 32'hE065;
  int          failures = 0;
  int          cmp_count = 0;
  always #10 ref_clk = ~ref_clk;
  rotdp_core rotdp_core_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .instr_word(instr_word), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
    .bank_select_reg(bank_select_reg), .fsr2_base(fsr2_base), .file_rdata(file_rdata),
    .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
    .w_reg(w_reg), .carry_flag(carry_flag), .neg_flag(neg_flag), .zero_flag(zero_flag),
    .q_phase(q_phase), .instr_done(instr_done), .instr_hit(instr_hit));
  ////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Four cycles per instruction, five when Q4 is stalled; calls chain back to back
  task automatic run(input logic [5:0] op);
    logic [7:0]  f, d8, r;
    logic        d, a, v, s, rot, nc;
    logic [11:0] ea;
    {d, a, f} = 10'($random(seed));
    d8 = 8'($random(seed));
    {ext_set_en, bank_select_reg, fsr2_base} = 13'($random(seed));
    v = (3'($random(seed)) != 3'h0);
    s = (2'($random(seed)) == 2'h0);
    rot = v && (op inside {6'h0D, 6'h11, 6'h0C});
    case (op)
      6'h0D: {nc, r} = {d8, mc};
      6'h11: {nc, r} = {mc, d8[6:0], d8[7]};
      default: {r, nc} = {mc, d8};
    endcase
    if (a) ea = {bank_select_reg, f};
    else if (ext_set_en && f <= 8'h5F) ea = {4'h0, fsr2_base + f};
    else ea = {(f >= 8'h60) ? 4'hF : 4'h0, f};
    instr_word = {op, d, a, f};
    instr_valid = v;
    file_rdata = d8;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk({file_rd, instr_hit}, {rot, rot}, "read strobe");
    if (rot) chk(file_addr, ea, "address");
    repeat (2) @(negedge ref_clk);
    if (s) begin
      clk_en = 1'b0;
      @(negedge ref_clk);
      clk_en = 1'b1;
      chk({q_phase, w_reg}, {4'h8, mw}, "stalled state");
      chk({file_wr, instr_done, carry_flag}, {2'b00, mc}, "stalled flags");
    end
    @(negedge ref_clk);
    if (rot) begin
      mc = nc;
      mnz = {r[7], r == 8'h00};
      if (!d) mw = r;
      if (d) chk(file_wdata, r, "write data");
    end
    chk({neg_flag, zero_flag}, mnz, "flags");
    chk({file_wr, instr_done, carry_flag, w_reg}, {rot & d, rot, mc, mw}, "result");
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    chk({q_phase, w_reg}, 12'h100, "reset state");
    for (int i = 0; i < 200; i++) run(ops[i % 4]);
    end_of_test();
  end
  // Run needs at most about 1010 cycles
  initial begin
    #50000;
    failures++;
    end_of_test();
  end
endmodule
bind rotdp_core rotdp_checker rotdp_checker_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
  .instr_word(instr_word), .instr_valid(instr_valid), .file_rd(file_rd), .file_wr(file_wr),
  .w_reg(w_reg), .carry_flag(carry_flag), .q_phase(q_phase), .instr_done(instr_done),
  .instr_hit(instr_hit));
`default_nettype wire
